//--- lpc_pkg.sv
package lpc_pkg;

	// vector addresses fetched when the processor resumes
	localparam logic [15:0] VEC_RESET = 16'h1FFE;
	localparam logic [15:0] VEC_IRQ = 16'h1FFA;
	localparam logic [15:0] VEC_TIMER = 16'h1FF8;
	localparam logic [15:0] VEC_SER = 16'h1FF6;
	localparam logic [15:0] VEC_SPI = 16'h1FF4;

	// timer counter value forced by reset
	localparam logic [15:0] TMR_RESET = 16'hFFFC;
	localparam logic [15:0] TMR_TOP = 16'hFFFF;

	// core clock period in ns, dividers in core clock cycles
	localparam int CLK_PERIOD_NS = 100;
	localparam int TMR_PRESCALE = 4;
	localparam int SER_DIV = 16;
	localparam int SPI_DIV = 2;
	localparam int DIV_W = 8;

	// spi slave character length
	localparam int SPI_BITS = 8;

	// spi configuration word layout
	localparam int SPI_CFG_EN = 0;
	localparam int SPI_CFG_MSTR = 1;
	localparam int SPI_CFG_W = 2;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_WAIT = 3'b010,
		ST_STOP = 3'b100
	} pm_state_t;

endpackage : lpc_pkg

//--- spi_link_if.sv
`timescale 1ns/10ps
`default_nettype none

interface spi_link_if;
	logic stopped;
	logic spi_en;
	logic spi_master;
	logic spi_flag;
	logic [lpc_pkg::SPI_BITS-1:0] rx_data;

	modport ctrl (output stopped, input spi_en, input spi_master,
		input spi_flag, input rx_data);
	modport spi (input stopped, output spi_en, output spi_master,
		output spi_flag, output rx_data);
endinterface : spi_link_if

`default_nettype wire

//--- spi_slave_core.sv
`timescale 1ns/10ps
`default_nettype none

module spi_slave_core (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic cfg_we,
	input wire logic [lpc_pkg::SPI_CFG_W-1:0] cfg_wdata,
	input wire logic [lpc_pkg::SPI_BITS-1:0] tx_data,
	input wire logic tx_load,
	input wire logic flag_clr,
	input wire logic sck,
	input wire logic mosi,
	input wire logic ss_n,
	output logic miso,
	spi_link_if.spi lnk
);

	typedef struct packed {
		logic en;
		logic mstr;
		logic sck_prev;
		logic [lpc_pkg::SPI_BITS-1:0] shreg;
		logic [3:0] bits;
		logic done_pend;
		logic flag;
		logic [lpc_pkg::SPI_BITS-1:0] rx;
		logic miso;
	} spi_st_t;

	spi_st_t q, d;
	logic done;

	always_comb begin
		d = q;
		done = 1'b0;
		d.sck_prev = sck;
		if (cfg_we) begin
			d.en = cfg_wdata[lpc_pkg::SPI_CFG_EN];
			d.mstr = cfg_wdata[lpc_pkg::SPI_CFG_MSTR];
		end
		if (tx_load) begin
			d.shreg = tx_data;
		end
		// slave shifting runs on the master's clock, even in stop
		if (q.en && !q.mstr && !ss_n && sck && !q.sck_prev) begin
			d.shreg = {q.shreg[lpc_pkg::SPI_BITS-2:0], mosi};
			if (q.bits == 4'(lpc_pkg::SPI_BITS - 1)) begin
				d.bits = 4'h0;
				done = 1'b1;
				d.rx = {q.shreg[lpc_pkg::SPI_BITS-2:0], mosi};
			end else begin
				d.bits = q.bits + 4'h1;
			end
		end
		if (q.en && !q.mstr) begin
			d.miso = d.shreg[lpc_pkg::SPI_BITS-1];
		end
		if (flag_clr) begin
			d.flag = 1'b0;
		end
		// completion in stop is held back until the wake
		if (done && lnk.stopped) begin
			d.done_pend = 1'b1;
		end
		if (done && !lnk.stopped) begin
			d.flag = 1'b1;
		end
		if (q.done_pend && !lnk.stopped) begin
			d.done_pend = 1'b0;
			d.flag = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign miso = q.miso;
	assign lnk.spi_en = q.en;
	assign lnk.spi_master = q.mstr;
	assign lnk.spi_flag = q.flag;
	assign lnk.rx_data = q.rx;

endmodule : spi_slave_core

`default_nettype wire

//--- low_power_ctrl.sv
// What this block does
// - stop instruction switches the oscillator off
// - stop entry clears the interrupt mask bit
// - stop keeps registers, memory and lines unchanged
// - stop ends on irq or reset, vectors
// - wait halts processor, clock and peripherals run
// - wait entry clears mask, other state unchanged
// - wait ends on any interrupt, loads vector
// - timer holds in stop, resumes after irq
// - reset exit loads timer with fixed value
// - stop halts the serial baud generator
// - frozen transmission resumes after irq wake
// - stop drops a partly received character
// - stop freezes spi bit rate generator
// - reset exit clears and disables spi
// - spi slave keeps shifting during stop
// - slave completion flag deferred until irq wake
// - enabled output drivers keep levels in stop
// - timer, serial, spi, irq, reset end wait
// - timer runs in wait, serial may be off
// - interrupt exit keeps peripherals, reset disables
// - compare pin low in reset until match
`timescale 1ns/10ps
`default_nettype none

module low_power_ctrl #(
	parameter int PRESCALE = lpc_pkg::TMR_PRESCALE,
	parameter int SER_DIV = lpc_pkg::SER_DIV,
	parameter int SPI_DIV = lpc_pkg::SPI_DIV
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// processor side
	input wire logic stop_exec,
	input wire logic wait_exec,
	output logic osc_en,
	output logic cpu_clk_en,
	output logic imask_clr,
	output logic vec_load,
	output logic [15:0] vec_addr,
	output logic io_hold,
	// pins
	input wire logic irq_n,
	// timer
	input wire logic [15:0] cmp_value,
	input wire logic cmp_level,
	input wire logic cmp_irq_en,
	input wire logic cmp_flag_clr,
	input wire logic ovf_irq_en,
	input wire logic ovf_flag_clr,
	output logic [15:0] timer_count,
	output logic compare_match_flag,
	output logic ovf_flag,
	output logic compare_output_pin,
	// async serial interface
	input wire logic async_serial_interface_en,
	input wire logic async_serial_interface_irq,
	input wire logic ser_rx_busy,
	output logic ser_baud_tick,
	output logic ser_rx_flush,
	// spi
	input wire logic spi_cfg_we,
	input wire logic [lpc_pkg::SPI_CFG_W-1:0] spi_cfg_wdata,
	input wire logic [lpc_pkg::SPI_BITS-1:0] spi_tx_data,
	input wire logic spi_tx_load,
	input wire logic spi_flag_clr,
	input wire logic spi_irq_en,
	input wire logic spi_sck_in,
	input wire logic spi_mosi_in,
	input wire logic spi_ss_n,
	output logic spi_miso,
	output logic spi_rate_tick,
	output logic spi_flag,
	output logic [lpc_pkg::SPI_BITS-1:0] spi_rx_data
);

	////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		lpc_pkg::pm_state_t st;
		logic osc_en;
		logic cpu_en;
		logic imask_clr;
		logic vec_load;
		logic [15:0] vec;
		logic io_hold;
		logic [15:0] tcnt;
		logic [lpc_pkg::DIV_W-1:0] pre;
		logic cmp_pin;
		logic cmp_flag;
		logic ovf_flag;
		logic [lpc_pkg::DIV_W-1:0] ser_div;
		logic [lpc_pkg::DIV_W-1:0] spi_div;
		logic ser_tick;
		logic spi_tick;
		logic rx_flush;
		logic spi_flag;
		logic [lpc_pkg::SPI_BITS-1:0] spi_rx;
	} pm_t;

	pm_t q, d;
	logic running;
	logic tmr_tick;
	logic irq_pin;
	logic tmr_irq;
	logic ser_irq;
	logic spi_irq;

	spi_link_if lnk ();

	// divider step: returns 1 on the last count of a period
	function automatic logic div_last(
		input logic [lpc_pkg::DIV_W-1:0] cnt,
		input int period
	);
		div_last = (cnt == lpc_pkg::DIV_W'(period - 1));
	endfunction : div_last

	function automatic logic [lpc_pkg::DIV_W-1:0] div_next(
		input logic [lpc_pkg::DIV_W-1:0] cnt,
		input int period
	);
		if (cnt == lpc_pkg::DIV_W'(period - 1)) begin
			div_next = '0;
		end else begin
			div_next = cnt + lpc_pkg::DIV_W'(1);
		end
	endfunction : div_next

	////////////////////////////////////////////////////////////////////
	// spi slave engine

	spi_slave_core u_spi (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.cfg_we(spi_cfg_we),
		.cfg_wdata(spi_cfg_wdata),
		.tx_data(spi_tx_data),
		.tx_load(spi_tx_load),
		.flag_clr(spi_flag_clr),
		.sck(spi_sck_in),
		.mosi(spi_mosi_in),
		.ss_n(spi_ss_n),
		.miso(spi_miso),
		.lnk(lnk.spi)
	);

	assign lnk.stopped = (q.st == lpc_pkg::ST_STOP);

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		d = q;
		// irq pin is only level sensed; the waker must hold it low
		irq_pin = !irq_n;
		running = (q.st != lpc_pkg::ST_STOP);
		tmr_irq = (q.cmp_flag && cmp_irq_en) || (q.ovf_flag && ovf_irq_en);
		ser_irq = async_serial_interface_irq && async_serial_interface_en;
		spi_irq = lnk.spi_flag && spi_irq_en;
		tmr_tick = running && div_last(q.pre, PRESCALE);
		d.imask_clr = 1'b0;
		d.vec_load = 1'b0;
		d.rx_flush = 1'b0;
		d.ser_tick = 1'b0;
		d.spi_tick = 1'b0;

		unique case (q.st)
			lpc_pkg::ST_RUN: begin
				if (stop_exec) begin
					d.st = lpc_pkg::ST_STOP;
					d.osc_en = 1'b0;
					d.cpu_en = 1'b0;
					d.imask_clr = 1'b1;
					d.io_hold = 1'b1;
					// a character in flight on receive cannot finish
					d.rx_flush = ser_rx_busy;
				end else if (wait_exec) begin
					d.st = lpc_pkg::ST_WAIT;
					d.cpu_en = 1'b0;
					d.imask_clr = 1'b1;
				end
			end
			lpc_pkg::ST_STOP: begin
				// only the irq pin; reset acts through rst_n
				if (irq_pin) begin
					d.st = lpc_pkg::ST_RUN;
					d.osc_en = 1'b1;
					d.cpu_en = 1'b1;
					d.io_hold = 1'b0;
					d.vec_load = 1'b1;
					d.vec = lpc_pkg::VEC_IRQ;
				end
			end
			lpc_pkg::ST_WAIT: begin
				// fixed priority: pin, timer, serial, spi
				if (irq_pin || tmr_irq || ser_irq || spi_irq) begin
					d.st = lpc_pkg::ST_RUN;
					d.cpu_en = 1'b1;
					d.vec_load = 1'b1;
					if (irq_pin) begin
						d.vec = lpc_pkg::VEC_IRQ;
					end else if (tmr_irq) begin
						d.vec = lpc_pkg::VEC_TIMER;
					end else if (ser_irq) begin
						d.vec = lpc_pkg::VEC_SER;
					end else begin
						d.vec = lpc_pkg::VEC_SPI;
					end
				end
			end
			default: begin
				d.st = lpc_pkg::ST_RUN;
				d.osc_en = 1'b1;
				d.cpu_en = 1'b1;
				d.io_hold = 1'b0;
			end
		endcase

		////////////////////////////////////////////////////////////////
		// timer: frozen in stop, never gated in wait

		if (running) begin
			d.pre = div_next(q.pre, PRESCALE);
		end
		if (cmp_flag_clr) begin
			d.cmp_flag = 1'b0;
		end
		if (ovf_flag_clr) begin
			d.ovf_flag = 1'b0;
		end
		if (tmr_tick) begin
			d.tcnt = q.tcnt + 16'h0001;
			// set beats a clear in the same cycle
			if (q.tcnt == lpc_pkg::TMR_TOP) begin
				d.ovf_flag = 1'b1;
			end
			if (q.tcnt == cmp_value) begin
				d.cmp_flag = 1'b1;
				d.cmp_pin = cmp_level;
			end
		end

		////////////////////////////////////////////////////////////////
		// serial and spi rate generators

		// no ticks in stop: transmit freezes mid bit and resumes
		if (running && async_serial_interface_en) begin
			d.ser_div = div_next(q.ser_div, SER_DIV);
			d.ser_tick = div_last(q.ser_div, SER_DIV);
		end
		if (running && lnk.spi_en && lnk.spi_master) begin
			d.spi_div = div_next(q.spi_div, SPI_DIV);
			d.spi_tick = div_last(q.spi_div, SPI_DIV);
		end
		d.spi_flag = lnk.spi_flag;
		d.spi_rx = lnk.rx_data;
	end

	////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// reset exit clears flags and dividers, keeps oscillator and cpu clock on, vectors to reset
			q <= '0;
			q.st <= lpc_pkg::ST_RUN;
			q.osc_en <= 1'b1;
			q.cpu_en <= 1'b1;
			q.vec_load <= 1'b1;
			q.vec <= lpc_pkg::VEC_RESET;
			q.tcnt <= lpc_pkg::TMR_RESET;
			q.cmp_pin <= 1'b0;
		end else if (ce) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign osc_en = q.osc_en;
	assign cpu_clk_en = q.cpu_en;
	assign imask_clr = q.imask_clr;
	assign vec_load = q.vec_load;
	assign vec_addr = q.vec;
	assign io_hold = q.io_hold;
	assign timer_count = q.tcnt;
	assign compare_match_flag = q.cmp_flag;
	assign ovf_flag = q.ovf_flag;
	// pin level held by its flop through stop
	assign compare_output_pin = q.cmp_pin;
	assign ser_baud_tick = q.ser_tick;
	assign ser_rx_flush = q.rx_flush;
	assign spi_rate_tick = q.spi_tick;
	assign spi_flag = q.spi_flag;
	assign spi_rx_data = q.spi_rx;

endmodule : low_power_ctrl

`default_nettype wire

//--- low_power_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none

module low_power_ctrl_chk #(
	parameter int PRESCALE = lpc_pkg::TMR_PRESCALE
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic stop_exec,
	input wire logic wait_exec,
	input wire logic irq_n,
	input wire logic ser_rx_busy,
	input wire logic osc_en,
	input wire logic cpu_clk_en,
	input wire logic imask_clr,
	input wire logic vec_load,
	input wire logic [15:0] vec_addr,
	input wire logic io_hold,
	input wire logic [15:0] timer_count,
	input wire logic compare_output_pin,
	input wire logic ser_baud_tick,
	input wire logic ser_rx_flush,
	input wire logic spi_rate_tick,
	input wire logic spi_flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_STOP_IN: assert property (
		ce && stop_exec && osc_en && cpu_clk_en
		|=> !osc_en && !cpu_clk_en && imask_clr && io_hold)
		else $error("stop entry wrong");
	AST_WAIT_IN: assert property (
		ce && wait_exec && !stop_exec && osc_en && cpu_clk_en
		|=> osc_en && !cpu_clk_en && imask_clr && !io_hold)
		else $error("wait entry wrong");
	AST_STOP_HOLD: assert property (
		!osc_en && irq_n |=> !osc_en && !vec_load
		&& $stable(timer_count) && $stable(compare_output_pin))
		else $error("state moved in stop");
	AST_STOP_WAKE: assert property (
		ce && !osc_en && !irq_n |=> osc_en && cpu_clk_en && !io_hold
		&& vec_load && vec_addr == lpc_pkg::VEC_IRQ ##1 !vec_load)
		else $error("stop wake wrong");
	AST_WAIT_WAKE: assert property (
		ce && osc_en && !cpu_clk_en && !irq_n
		|=> cpu_clk_en && vec_load && vec_addr == lpc_pkg::VEC_IRQ)
		else $error("wait pin wake wrong");
	AST_RESET_VAL: assert property (
		$rose(rst_n) |-> timer_count == lpc_pkg::TMR_RESET && vec_load
		&& vec_addr == lpc_pkg::VEC_RESET && !compare_output_pin
		&& !spi_flag && osc_en)
		else $error("reset values wrong");
	AST_TICK_STOP: assert property (
		!osc_en ##1 !osc_en |-> !ser_baud_tick && !spi_rate_tick)
		else $error("rate tick in stop");
	AST_FLUSH: assert property (
		ce && stop_exec && osc_en && cpu_clk_en
		|=> ser_rx_flush == $past(ser_rx_busy) ##1 !ser_rx_flush)
		else $error("receive flush wrong");
	AST_FLAG_HELD: assert property (
		(!osc_en) [*3] |-> !$rose(spi_flag))
		else $error("spi flag set in stop");
	AST_WAIT_TMR: assert property (
		(ce && osc_en && !cpu_clk_en) [*5]
		|-> timer_count != $past(timer_count, PRESCALE))
		else $error("timer idle in wait");
endmodule : low_power_ctrl_chk

`default_nettype wire

//--- lpc_partner.sv
`timescale 1ns/10ps
`default_nettype none

module lpc_partner (
	input wire logic core_clk,
	input wire logic miso,
	output logic irq_n,
	output logic sck,
	output logic mosi,
	output logic ss_n
);
	logic [7:0] miso_seen;

	initial begin
		irq_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b1;
		ss_n = 1'b1;
		miso_seen = 8'h00;
	end

	// held by the caller until the wake shows, so it cannot be missed
	task automatic pull(input logic low);
		irq_n = !low;
	endtask : pull

	// master side, msb first; sck idles low between frames
	task automatic xfer(input logic [7:0] b);
		@(negedge core_clk);
		ss_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi = b[i];
			repeat (3) @(negedge core_clk);
			miso_seen = {miso_seen[6:0], miso};
			sck = 1'b1;
			repeat (3) @(negedge core_clk);
			sck = 1'b0;
		end
		mosi = ~mosi;
		ss_n = 1'b1;
	endtask : xfer
endmodule : lpc_partner

`default_nettype wire

//--- low_power_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

module low_power_ctrl_tb;
	localparam logic [15:0] VECS [3] = '{lpc_pkg::VEC_SER,
		lpc_pkg::VEC_SPI, lpc_pkg::VEC_IRQ};
	logic core_clk, rst_n, ce, stop_exec, wait_exec, osc_en, cpu_clk_en;
	logic imask_clr, vec_load, io_hold, irq_n, cmp_level, cmp_irq_en;
	logic cmp_flag_clr, ovf_irq_en, ovf_flag_clr, compare_match_flag;
	logic ovf_flag, compare_output_pin, ser_rx_busy, ser_baud_tick;
	logic async_serial_interface_en, async_serial_interface_irq;
	logic ser_rx_flush, spi_cfg_we, spi_tx_load, spi_flag_clr, spi_irq_en;
	logic spi_sck_in, spi_mosi_in, spi_ss_n, spi_miso, spi_rate_tick;
	logic spi_flag;
	logic [15:0] vec_addr, cmp_value, timer_count, held;
	logic [lpc_pkg::SPI_CFG_W-1:0] spi_cfg_wdata;
	logic [7:0] spi_tx_data, spi_rx_data;
	int err_count, n_compared;

	low_power_ctrl dut_u (.core_clk, .rst_n, .ce, .stop_exec, .wait_exec,
		.osc_en, .cpu_clk_en, .imask_clr, .vec_load, .vec_addr, .io_hold,
		.irq_n, .cmp_value, .cmp_level, .cmp_irq_en, .cmp_flag_clr,
		.ovf_irq_en, .ovf_flag_clr, .timer_count, .compare_match_flag,
		.ovf_flag, .compare_output_pin, .async_serial_interface_en,
		.async_serial_interface_irq, .ser_rx_busy, .ser_baud_tick,
		.ser_rx_flush, .spi_cfg_we, .spi_cfg_wdata, .spi_tx_data,
		.spi_tx_load, .spi_flag_clr, .spi_irq_en, .spi_sck_in, .spi_mosi_in,
		.spi_ss_n, .spi_miso, .spi_rate_tick, .spi_flag, .spi_rx_data);
	lpc_partner partner_u (.core_clk, .miso(spi_miso), .irq_n,
		.sck(spi_sck_in), .mosi(spi_mosi_in), .ss_n(spi_ss_n));

	always #50 core_clk = ~core_clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("compared %0d, mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	task automatic go(input logic stp);
		@(negedge core_clk);
		stop_exec = stp;
		wait_exec = !stp;
		@(negedge core_clk);
		stop_exec = 1'b0;
		wait_exec = 1'b0;
	endtask : go

	// bounded: a wake that never comes ends the run
	task automatic wake_check(input logic [15:0] exp);
		int k;
		k = 0;
		while (vec_load !== 1'b1 && k < 60) begin
			@(negedge core_clk);
			k++;
		end
		if (k == 60) begin
			err_count++;
			tally_and_finish;
		end
		chk(vec_addr, exp);
	endtask : wake_check

	////////////////////////////////////////////////////////////////////
	task automatic t_stop;
		spi_cfg_we = 1'b1;
		spi_cfg_wdata = 2'h1;
		cyc(1);
		spi_cfg_we = 1'b0;
		spi_tx_data = 8'hA5;
		spi_tx_load = 1'b1;
		ser_rx_busy = 1'b1;
		cyc(1);
		spi_tx_load = 1'b0;
		go(1'b1);
		chk(ser_rx_flush, 1'b1);
		chk(osc_en, 1'b0);
		chk(imask_clr, 1'b1);
		chk(io_hold, 1'b1);
		ser_rx_busy = 1'b0;
		held = timer_count;
		partner_u.xfer(8'h3C);
		chk(timer_count, held);
		chk(spi_rx_data, 8'h3C);
		chk(partner_u.miso_seen, 8'hA5);
		chk(spi_flag, 1'b0);
		partner_u.pull(1'b1);
		wake_check(lpc_pkg::VEC_IRQ);
		partner_u.pull(1'b0);
		cyc(3);
		chk(spi_flag, 1'b1);
		cyc(5);
		// eight running cycles since the wake give exactly two ticks
		chk(timer_count, held + 16'h2);
		$display("stop test done");
	endtask : t_stop

	task automatic t_wait_cmp;
		chk(compare_output_pin, 1'b0);
		cmp_level = 1'b1;
		cmp_irq_en = 1'b1;
		cmp_value = timer_count + 16'h3;
		go(1'b0);
		chk(osc_en, 1'b1);
		chk(cpu_clk_en, 1'b0);
		wake_check(lpc_pkg::VEC_TIMER);
		chk(compare_output_pin, 1'b1);
		chk(compare_match_flag, 1'b1);
		cmp_irq_en = 1'b0;
		cmp_flag_clr = 1'b1;
		cyc(1);
		cmp_flag_clr = 1'b0;
		$display("wait timer test done");
	endtask : t_wait_cmp

	// serial, spi, then pin against a pending spi flag: pin must win
	task automatic t_wait_src;
		for (int i = 0; i < 3; i++) begin
			async_serial_interface_irq = (i == 0);
			spi_irq_en = (i > 0);
			go(1'b0);
			partner_u.pull(i == 2);
			wake_check(VECS[i]);
			partner_u.pull(1'b0);
			async_serial_interface_irq = 1'b0;
		end
		chk(spi_flag, 1'b1);
		chk(spi_rx_data, 8'h3C);
		chk(ovf_flag, 1'b1);
		$display("wait source test done");
	endtask : t_wait_src

	task automatic t_reset_exit;
		go(1'b1);
		rst_n = 1'b0;
		cyc(1);
		rst_n = 1'b1;
		chk(timer_count, lpc_pkg::TMR_RESET);
		chk(vec_addr, lpc_pkg::VEC_RESET);
		chk(spi_flag, 1'b0);
		chk(ovf_flag, 1'b0);
		held = {8'h00, spi_rx_data};
		partner_u.xfer(8'h96);
		chk(spi_rx_data, held[7:0]);
		chk(spi_flag, 1'b0);
		$display("reset exit test done");
	endtask : t_reset_exit

	////////////////////////////////////////////////////////////////////
	initial begin
		{core_clk, rst_n, stop_exec, wait_exec, cmp_level, cmp_irq_en,
			cmp_flag_clr, ovf_irq_en, ovf_flag_clr, ser_rx_busy,
			async_serial_interface_irq, spi_cfg_we, spi_tx_load,
			spi_flag_clr, spi_irq_en, spi_cfg_wdata, spi_tx_data} = '0;
		ce = 1'b1;
		async_serial_interface_en = 1'b1;
		// far from the reset count, so no early match disturbs the pin
		cmp_value = 16'h8000;
		cyc(12);
		chk(timer_count, lpc_pkg::TMR_RESET);
		chk(compare_output_pin, 1'b0);
		rst_n = 1'b1;
		cyc(2);
		t_stop;
		t_wait_cmp;
		t_wait_src;
		t_reset_exit;
		tally_and_finish;
	end
endmodule : low_power_ctrl_tb

bind low_power_ctrl low_power_ctrl_chk #(.PRESCALE(PRESCALE)) chk_u (
	.core_clk, .rst_n, .ce, .stop_exec, .wait_exec, .irq_n, .ser_rx_busy,
	.osc_en, .cpu_clk_en, .imask_clr, .vec_load, .vec_addr, .io_hold,
	.timer_count, .compare_output_pin, .ser_baud_tick, .ser_rx_flush,
	.spi_rate_tick, .spi_flag);

`default_nettype wire
